// File: core/bca_cond_eval.sv
`timescale 1ns/100ps
module bca_cond_eval
   import bca_pkg::*;
(
   input wire logic [3:0] sel,
   input wire bca_flags_s flags,
   output logic taken
);

   logic sv_w;

   assign sv_w = flags.s ^ flags.v;

   always_comb begin
      case (sel)
         // RL3: never and always
         BCA_SEL_NEVER: taken = 1'b0;
         BCA_SEL_ALWAYS: taken = 1'b1;
         // RL4: carry tests
         BCA_SEL_CARRY_SET: taken = flags.c;
         BCA_SEL_CARRY_CLEAR: taken = ~flags.c;
         // RL5: zero tests
         BCA_SEL_RESULT_ZERO: taken = flags.z;
         BCA_SEL_WHEN_RESULT_NONZERO: taken = ~flags.z;
         // RL6: sign and overflow
         BCA_SEL_WHEN_POSITIVE: taken = ~flags.s;
         BCA_SEL_WHEN_NEGATIVE: taken = flags.s;
         BCA_SEL_WHEN_SIGNED_WRAP: taken = flags.v;
         BCA_SEL_WHEN_NO_SIGNED_WRAP: taken = ~flags.v;
         // RL7: signed order
         BCA_SEL_SIGNED_AT_OR_ABOVE: taken = ~sv_w;
         BCA_SEL_SIGNED_BELOW: taken = sv_w;
         BCA_SEL_SIGNED_ABOVE: taken = ~(flags.z | sv_w);
         BCA_SEL_SIGNED_AT_OR_BELOW: taken = flags.z | sv_w;
         // RL8: unsigned order
         BCA_SEL_UNSIGNED_ABOVE: taken = ~flags.c & ~flags.z;
         BCA_SEL_UNSIGNED_AT_OR_BELOW: taken = flags.c | flags.z;
         default: taken = 1'b0;
      endcase
   end

endmodule

// File: core/bca_top.sv
// Function
// RL1: Jump decision comes only from the 4-bit selector and current flags.
// RL2: Only carry, zero, sign and overflow flags feed the condition test.
// RL3: Selector 0000 never jumps, 1000 always jumps, whatever the flags.
// RL4: 0111 true on carry set, 1111 true on carry clear.
// RL5: 0110 true on zero set, 1110 true on zero clear.
// RL6: 1101 sign clear, 0101 sign set, 0100 overflow set, 1100 overflow clear.
// RL7: 1001/0001 test sign XOR overflow; 1010/0010 add zero OR to that.
// RL8: 1011 needs carry and zero clear; 0011 needs carry or zero set.
// RL9: Add forms the 8-bit sum of destination and source; source untouched.
// RL10: Add-with-carry adds the present carry flag as an extra addend.
// RL11: Carry in lets a low-byte carry ripple into the next high byte.
// RL12: Carry flag set on carry out of the top bit, else cleared.
// RL13: Zero flag set on all-zero result, sign flag on negative result.
// RL14: Overflow set when like-signed operands give opposite-signed result.
// RL15: Condition tests never change flags; taken redirects, false continues.
`timescale 1ns/100ps
module bca_top
   import bca_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic seq_alu_start,
   input wire bca_alu_req_s seq_alu_req,
   input wire logic seq_jump_eval,
   input wire logic [3:0] jump_condition_selector,
   output logic [7:0] alu_result,
   output logic alu_result_valid,
   output bca_flags_s flags_out,
   output logic jump_valid,
   output logic jump_taken,
   output logic jump_redirect,
   output logic jump_continue
);

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   logic setup_w;
   logic access_w;
   logic hit_flags_w;
   logic hit_alu_w;
   logic hit_jump_w;
   logic stall_w;
   logic flag_wr_w;
   logic apb_alu_go_w;
   logic apb_jump_go_w;

   assign setup_w = psel & ~penable;
   assign access_w = psel & penable;
   assign hit_flags_w = (paddr == BCA_OFS_FLAGS);
   assign hit_alu_w = (paddr == BCA_OFS_ALU_CMD);
   assign hit_jump_w = (paddr == BCA_OFS_JUMP);

   // Sequencer owns the datapath; a colliding bus add or jump command waits a cycle
   assign stall_w = access_w & pwrite &
                    ((hit_alu_w & seq_alu_start) | (hit_jump_w & seq_jump_eval));
   assign pready = ~stall_w;

   assign flag_wr_w = access_w & pwrite & hit_flags_w;
   assign apb_alu_go_w = access_w & pwrite & hit_alu_w & ~seq_alu_start;
   assign apb_jump_go_w = access_w & pwrite & hit_jump_w & ~seq_jump_eval;

   ////////////////////////////////////////////////////////////////////////////
   // Adder

   bca_flags_s flags_q;
   bca_flags_s flags_new_w;
   bca_alu_req_s req_w;
   logic alu_go_w;
   logic carry_in_w;
   logic [8:0] sum9_w;
   logic [7:0] res_w;
   logic [7:0] alu_result_q;
   logic alu_valid_q;

   assign alu_go_w = seq_alu_start | apb_alu_go_w;

   always_comb begin
      if (seq_alu_start) begin
         req_w = seq_alu_req;
      end else begin
         req_w.dst = pwdata[BCA_CMD_DST_LSB +: 8];
         req_w.src = pwdata[BCA_CMD_SRC_LSB +: 8];
         req_w.with_carry = pwdata[BCA_CMD_CARRY_BIT];
      end
   end

   // RL10: carry flag as addend
   // RL11: ripples low-byte carry upward
   assign carry_in_w = req_w.with_carry & flags_q.c;

   // RL9: two's-complement sum
   assign sum9_w = {1'b0, req_w.dst} + {1'b0, req_w.src} + {8'h00, carry_in_w};
   assign res_w = sum9_w[7:0];

   always_comb begin
      // RL12: carry out of bit 7
      flags_new_w.c = sum9_w[8];
      // RL13: zero and sign
      flags_new_w.z = (res_w == 8'h00);
      flags_new_w.s = res_w[7];
      // RL14: signed overflow
      flags_new_w.v = (req_w.dst[7] == req_w.src[7]) & (res_w[7] != req_w.dst[7]);
   end

   // Add update beats a bus write of the flags in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= BCA_FLAGS_RST;
      end else if (alu_go_w) begin
         flags_q <= flags_new_w;
      end else if (flag_wr_w) begin
         flags_q <= pwdata[BCA_FLAGS_LSB +: 4];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alu_result_q <= BCA_RESULT_RST;
         alu_valid_q <= 1'b0;
      end else begin
         alu_valid_q <= alu_go_w;
         if (alu_go_w) begin
            alu_result_q <= res_w;
         end
      end
   end

   assign alu_result = alu_result_q;
   assign alu_result_valid = alu_valid_q;
   assign flags_out = flags_q;

   ////////////////////////////////////////////////////////////////////////////
   // Condition evaluation

   logic jmp_go_w;
   logic [3:0] jmp_sel_w;
   logic taken_w;
   logic [3:0] last_sel_q;
   logic jump_valid_q;
   logic jump_taken_q;

   assign jmp_go_w = seq_jump_eval | apb_jump_go_w;
   assign jmp_sel_w = seq_jump_eval ? jump_condition_selector :
                      pwdata[BCA_JMP_SEL_LSB +: 4];

   // RL1: selector and flags only
   // RL2: four flags in
   bca_cond_eval bca_cond_eval_inst (
      .sel(jmp_sel_w),
      .flags(flags_q),
      .taken(taken_w)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_sel_q <= BCA_SEL_RST;
         jump_valid_q <= 1'b0;
         jump_taken_q <= 1'b0;
      end else begin
         jump_valid_q <= jmp_go_w;
         if (jmp_go_w) begin
            last_sel_q <= jmp_sel_w;
            jump_taken_q <= taken_w;
         end
      end
   end

   // RL15: redirect or fall through
   assign jump_valid = jump_valid_q;
   assign jump_taken = jump_taken_q;
   assign jump_redirect = jump_valid_q & jump_taken_q;
   assign jump_continue = jump_valid_q & ~jump_taken_q;

   ////////////////////////////////////////////////////////////////////////////
   // Read path, sampled in the setup cycle so prdata comes from flops

   logic [31:0] prdata_q;
   logic pslverr_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= BCA_RDATA_RST;
         pslverr_q <= 1'b0;
      end else if (setup_w) begin
         prdata_q <= BCA_RDATA_RST;
         pslverr_q <= ~(hit_flags_w | hit_alu_w | hit_jump_w);
         if (!pwrite) begin
            if (hit_flags_w) begin
               prdata_q[BCA_FLAGS_LSB +: 4] <= flags_q;
            end
            if (hit_alu_w) begin
               prdata_q[BCA_CMD_DST_LSB +: 8] <= alu_result_q;
            end
            if (hit_jump_w) begin
               prdata_q[BCA_JMP_SEL_LSB +: 4] <= last_sel_q;
               prdata_q[BCA_JMP_TAKEN_BIT] <= jump_taken_q;
            end
         end
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q & access_w;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_jump(logic [3:0] code);
      jmp_go_w && (jmp_sel_w == code);
   endsequence

   sequence s_add(logic wc);
      alu_go_w && (req_w.with_carry == wc);
   endsequence

   AST_NEVER_TAKEN: assert property ( // RL3
      s_jump(BCA_SEL_NEVER) |=> jump_valid && !jump_taken && jump_continue)
      else $error("never selector jumped");

   AST_ALWAYS_TAKEN: assert property ( // RL3
      s_jump(BCA_SEL_ALWAYS) |=> jump_valid && jump_taken && jump_redirect)
      else $error("always selector did not jump");

   AST_CARRY_TESTS: assert property ( // RL4
      (s_jump(BCA_SEL_CARRY_SET) or s_jump(BCA_SEL_CARRY_CLEAR)) |=>
      jump_taken == ($past(flags_q.c) ^ last_sel_q[3]))
      else $error("carry test wrong");

   AST_ZERO_TESTS: assert property ( // RL5
      (s_jump(BCA_SEL_RESULT_ZERO) or s_jump(BCA_SEL_WHEN_RESULT_NONZERO)) |=>
      jump_taken == ($past(flags_q.z) ^ last_sel_q[3]))
      else $error("zero test wrong");

   AST_SIGN_TESTS: assert property ( // RL6
      (s_jump(BCA_SEL_WHEN_NEGATIVE) or s_jump(BCA_SEL_WHEN_POSITIVE)) |=>
      jump_taken == ($past(flags_q.s) ^ last_sel_q[3]))
      else $error("sign test wrong");

   AST_WRAP_TESTS: assert property ( // RL6
      (s_jump(BCA_SEL_WHEN_SIGNED_WRAP) or s_jump(BCA_SEL_WHEN_NO_SIGNED_WRAP)) |=>
      jump_taken == ($past(flags_q.v) ^ last_sel_q[3]))
      else $error("overflow test wrong");

   AST_SIGNED_ORDER: assert property ( // RL7
      s_jump(BCA_SEL_SIGNED_ABOVE) |=>
      jump_taken == !($past(flags_q.z) || ($past(flags_q.s) != $past(flags_q.v))))
      else $error("signed above test wrong");

   AST_SIGNED_BELOW: assert property ( // RL7
      s_jump(BCA_SEL_SIGNED_BELOW) |=>
      jump_taken == ($past(flags_q.s) != $past(flags_q.v)))
      else $error("signed below test wrong");

   AST_UNSIGNED_ABOVE: assert property ( // RL8
      s_jump(BCA_SEL_UNSIGNED_ABOVE) |=>
      jump_taken == (!$past(flags_q.c) && !$past(flags_q.z)))
      else $error("unsigned above test wrong");

   AST_ADD_SUM: assert property ( // RL9
      s_add(1'b0) |=> alu_result_valid &&
      ({flags_q.c, alu_result} == {1'b0, $past(req_w.dst)} + {1'b0, $past(req_w.src)}))
      else $error("plain add sum wrong");

   AST_ADC_SUM: assert property ( // RL10
      s_add(1'b1) ##0 flags_q.c |=>
      ({flags_q.c, alu_result} ==
       {1'b0, $past(req_w.dst)} + {1'b0, $past(req_w.src)} + 9'h001))
      else $error("carry not added");

   AST_CHAIN_CARRY: assert property ( // RL11
      s_add(1'b0) ##1 s_add(1'b1) |=>
      ({flags_q.c, alu_result} == {1'b0, $past(req_w.dst)} + {1'b0, $past(req_w.src)} +
       {8'h00, $past(flags_q.c)}))
      else $error("carry chain broken");

   AST_CARRY_OUT: assert property ( // RL12
      alu_go_w && (req_w.dst == 8'hFF) && (req_w.src != 8'h00) |=> flags_q.c)
      else $error("carry out not set");

   AST_ZERO_SIGN: assert property ( // RL13
      alu_result_valid |->
      (flags_q.z == (alu_result == 8'h00)) && (flags_q.s == alu_result[7]))
      else $error("zero or sign flag wrong");

   AST_OVERFLOW: assert property ( // RL14
      alu_result_valid |-> flags_q.v ==
      (($past(req_w.dst[7]) == $past(req_w.src[7])) &&
       (alu_result[7] != $past(req_w.dst[7]))))
      else $error("overflow flag wrong");

   AST_JUMP_KEEPS_FLAGS: assert property ( // RL15
      jmp_go_w && !alu_go_w && !flag_wr_w |=> $stable(flags_q) ##1 1'b1)
      else $error("jump changed flags");

endmodule

// File: pkg/bca_pkg.sv
package bca_pkg;

   localparam int unsigned BCA_DATA_W = 8;
   localparam int unsigned BCA_SEL_W = 4;
   localparam int unsigned BCA_ADDR_W = 12;

   // Jump condition selector codes
   localparam logic [3:0] BCA_SEL_NEVER = 4'h0;
   localparam logic [3:0] BCA_SEL_ALWAYS = 4'h8;
   localparam logic [3:0] BCA_SEL_CARRY_SET = 4'h7;
   localparam logic [3:0] BCA_SEL_CARRY_CLEAR = 4'hF;
   localparam logic [3:0] BCA_SEL_RESULT_ZERO = 4'h6;
   localparam logic [3:0] BCA_SEL_WHEN_RESULT_NONZERO = 4'hE;
   localparam logic [3:0] BCA_SEL_WHEN_POSITIVE = 4'hD;
   localparam logic [3:0] BCA_SEL_WHEN_NEGATIVE = 4'h5;
   localparam logic [3:0] BCA_SEL_WHEN_SIGNED_WRAP = 4'h4;
   localparam logic [3:0] BCA_SEL_WHEN_NO_SIGNED_WRAP = 4'hC;
   localparam logic [3:0] BCA_SEL_SIGNED_AT_OR_ABOVE = 4'h9;
   localparam logic [3:0] BCA_SEL_SIGNED_BELOW = 4'h1;
   localparam logic [3:0] BCA_SEL_SIGNED_ABOVE = 4'hA;
   localparam logic [3:0] BCA_SEL_SIGNED_AT_OR_BELOW = 4'h2;
   localparam logic [3:0] BCA_SEL_UNSIGNED_ABOVE = 4'hB;
   localparam logic [3:0] BCA_SEL_UNSIGNED_AT_OR_BELOW = 4'h3;
   // Aliases sharing a code
   localparam logic [3:0] BCA_SEL_WHEN_OPERANDS_MATCH = BCA_SEL_RESULT_ZERO;
   localparam logic [3:0] BCA_SEL_WHEN_OPERANDS_DIFFER = BCA_SEL_WHEN_RESULT_NONZERO;
   localparam logic [3:0] BCA_SEL_UNSIGNED_BELOW = BCA_SEL_CARRY_SET;
   localparam logic [3:0] BCA_SEL_UNSIGNED_AT_OR_ABOVE = BCA_SEL_CARRY_CLEAR;

   // Register byte offsets
   localparam logic [11:0] BCA_OFS_FLAGS = 12'h000;
   localparam logic [11:0] BCA_OFS_ALU_CMD = 12'h004;
   localparam logic [11:0] BCA_OFS_JUMP = 12'h008;

   // Field positions
   localparam int unsigned BCA_FLAGS_LSB = 0;
   localparam int unsigned BCA_CMD_DST_LSB = 0;
   localparam int unsigned BCA_CMD_SRC_LSB = 8;
   localparam int unsigned BCA_CMD_CARRY_BIT = 16;
   localparam int unsigned BCA_JMP_SEL_LSB = 0;
   localparam int unsigned BCA_JMP_TAKEN_BIT = 4;

   // Values after reset
   localparam logic [3:0] BCA_FLAGS_RST = 4'h0;
   localparam logic [7:0] BCA_RESULT_RST = 8'h00;
   localparam logic [3:0] BCA_SEL_RST = 4'h0;
   localparam logic [31:0] BCA_RDATA_RST = 32'h0000_0000;

   // Flags, carry in the top bit
   typedef struct packed {
      logic c;
      logic z;
      logic s;
      logic v;
   } bca_flags_s;

   typedef struct packed {
      logic with_carry;
      logic [7:0] src;
      logic [7:0] dst;
   } bca_alu_req_s;

endpackage

// File: verification/bca_seq_model.sv
`timescale 1ns/100ps
module bca_seq_model
   import bca_pkg::*;
(
   input wire logic pclk,
   output logic seq_alu_start,
   output bca_alu_req_s seq_alu_req,
   output logic seq_jump_eval,
   output logic [3:0] jump_condition_selector
);
   initial begin
      seq_alu_start = 1'h0;
      seq_alu_req = '0;
      seq_jump_eval = 1'h0;
      jump_condition_selector = 4'h0;
   end

   ////////////////////////////////////////////////////////////////
   // upper bytes set with_carry
   task automatic add(input logic [7:0] d, input logic [7:0] s, input logic wc);
      @(posedge pclk);
      seq_alu_start <= 1'h1;
      seq_alu_req <= '{with_carry: wc, src: s, dst: d};
      @(posedge pclk);
      seq_alu_start <= 1'h0;
      // Stale operands scrambled so nothing leans on them
      seq_alu_req <= ~seq_alu_req;
   endtask

   task automatic jump(input logic [3:0] sl);
      @(posedge pclk);
      seq_jump_eval <= 1'h1;
      jump_condition_selector <= sl;
      @(posedge pclk);
      seq_jump_eval <= 1'h0;
      jump_condition_selector <= ~jump_condition_selector;
   endtask
endmodule

// File: verification/bca_tb_top.sv
`timescale 1ns/100ps
module bca_tb_top
   import bca_pkg::*;
();
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic seq_alu_start, seq_jump_eval, alu_result_valid;
   logic jump_valid, jump_taken, jump_redirect, jump_continue;
   bca_alu_req_s seq_alu_req;
   logic [3:0] jump_condition_selector;
   logic [7:0] alu_result;
   bca_flags_s flags_out;
   logic [3:0] exp_f;
   int miscompares;
   int checked;

   bca_top bca_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .seq_alu_start(seq_alu_start), .seq_alu_req(seq_alu_req),
      .seq_jump_eval(seq_jump_eval), .jump_condition_selector(jump_condition_selector),
      .alu_result(alu_result), .alu_result_valid(alu_result_valid),
      .flags_out(flags_out), .jump_valid(jump_valid), .jump_taken(jump_taken),
      .jump_redirect(jump_redirect), .jump_continue(jump_continue));

   bca_seq_model bca_seq_model_inst (.pclk(pclk), .seq_alu_start(seq_alu_start),
      .seq_alu_req(seq_alu_req), .seq_jump_eval(seq_jump_eval),
      .jump_condition_selector(jump_condition_selector));

   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   function automatic logic cond_ref(input logic [3:0] sl, input logic [3:0] f);
      logic c, z, s, v, t;
      {c, z, s, v} = f;
      case (sl[2:0])
         3'h0: t = 1'h0;
         3'h1: t = s ^ v;
         3'h2: t = z | (s ^ v);
         3'h3: t = c | z;
         3'h4: t = v;
         3'h5: t = s;
         3'h6: t = z;
         default: t = c;
      endcase
      return sl[3] ? ~t : t;
   endfunction

   ////////////////////////////////////////////////////////////////
   task automatic run_add(input logic [7:0] d, input logic [7:0] s, input logic wc);
      logic [8:0] sum;
      sum = {1'h0, d} + {1'h0, s} + {8'h00, wc & exp_f[3]};
      exp_f = {sum[8], sum[7:0] == 8'h00, sum[7], (d[7] == s[7]) && (sum[7] != d[7])};
      bca_seq_model_inst.add(d, s, wc);
      #1;
      check(alu_result_valid, 1'h1);
      check(alu_result, sum[7:0]);
      check(flags_out.c, exp_f[3]);
      check({flags_out.z, flags_out.s}, exp_f[2:1]);
      check(flags_out.v, exp_f[0]);
   endtask

   task automatic t_reset();
      logic [31:0] rd;
      logic err;
      check({flags_out, alu_result, alu_result_valid, jump_valid, jump_taken}, 32'h0);
      apb(1'h0, BCA_OFS_FLAGS, 32'h0, rd, err);
      check(rd, 32'h0);
   endtask

   task automatic t_add();
      run_add(8'h12, 8'h03, 1'h0);
      run_add(8'h7F, 8'h01, 1'h0);
      run_add(8'h80, 8'h80, 1'h0);
      run_add(8'h80, 8'h7F, 1'h0);
      run_add(8'hFF, 8'h02, 1'h0);
      run_add(8'h00, 8'h00, 1'h1);
      run_add(8'h7F, 8'h00, 1'h1);
      run_add(8'hFF, 8'hFF, 1'h0);
      run_add(8'hFF, 8'h00, 1'h1);
   endtask

   task automatic t_jump();
      logic [31:0] rd;
      logic err;
      logic t;
      for (int f = 0; f < 16; f++) begin
         apb(1'h1, BCA_OFS_FLAGS, 32'(f), rd, err);
         exp_f = 4'(f);
         for (int sl = 0; sl < 16; sl++) begin
            t = cond_ref(4'(sl), exp_f);
            bca_seq_model_inst.jump(4'(sl));
            #1;
            check(jump_valid, 1'h1);
            check(jump_taken, t);
            check({jump_redirect, jump_continue}, {t, ~t});
            check(flags_out, exp_f);
         end
      end
   endtask

   task automatic t_apb();
      logic [31:0] rd;
      logic err;
      apb(1'h0, 12'hFFC, 32'h0, rd, err);
      check(err, 1'h1);
      check(rd, 32'h0);
      apb(1'h1, BCA_OFS_FLAGS, 32'h8, rd, err);
      apb(1'h1, BCA_OFS_ALU_CMD, 32'h0001_0310, rd, err);
      #1;
      check(alu_result, 8'h14);
      check(flags_out, 4'h0);
      apb(1'h0, BCA_OFS_ALU_CMD, 32'h0, rd, err);
      check(rd, 32'h14);
      apb(1'h1, BCA_OFS_JUMP, 32'h8, rd, err);
      apb(1'h0, BCA_OFS_JUMP, 32'h0, rd, err);
      check(rd, 32'h18);
   endtask

   // Bus add collides with a sequencer add and must wait behind it
   task automatic t_collide();
      logic [31:0] rd;
      logic err;
      fork
         apb(1'h1, BCA_OFS_ALU_CMD, 32'h0001_007F, rd, err);
         begin
            @(posedge pclk);
            bca_seq_model_inst.add(8'hF0, 8'h20, 1'h0);
         end
      join
      #1;
      check(alu_result, 8'h80);
      check(flags_out, 4'h3);
   endtask

   task automatic t_reset_mid();
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      t_reset();
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'h0;
      forever #20 pclk = ~pclk;
   end

   // Whole run is well under two thousand cycles
   initial begin
      #(40 * 5000);
      miscompares++;
      report_and_stop();
   end

   initial begin
      miscompares = 0;
      checked = 0;
      exp_f = 4'h0;
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      t_reset();
      t_add();
      t_jump();
      t_apb();
      t_collide();
      t_reset_mid();
      report_and_stop();
   end
endmodule
